// ---- common/ctm_cfg.svh ----
// constants for the compact match/pwm timer: offsets, fields, codes, resets
// =====================================================================
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// =====================================================================
// register byte offsets
`define CTM_OFS_CTRL 8'h00
`define CTM_OFS_MODE 8'h04
`define CTM_OFS_COUNT 8'h08
`define CTM_OFS_CMPA 8'h0c
`define CTM_OFS_FLAGS 8'h10
`define CTM_OFS_STAT 8'h14

// =====================================================================
// field positions
`define CTM_CTRL_P_LSB 0
`define CTM_CTRL_ON_BIT 3
`define CTM_CTRL_PRE_LSB 8
`define CTM_FLAG_A_BIT 0
`define CTM_FLAG_P_BIT 1
`define CTM_STAT_PIN_BIT 0
`define CTM_STAT_EN_BIT 1

// =====================================================================
// widths and counter geometry
`define CTM_CNT_W 10
`define CTM_P_W 3
`define CTM_P_SHIFT 7
`define CTM_PRE_W 8

// =====================================================================
// mode and output-function codes
`define CTM_MODE_CMP 2'b00
`define CTM_MODE_PWM 2'b10
`define CTM_MODE_TC 2'b11
`define CTM_IO_HOLD 2'b00
`define CTM_IO_LOW 2'b01
`define CTM_IO_HIGH 2'b10
`define CTM_IO_TGL 2'b11
`define CTM_PWM_INACT 2'b00
`define CTM_PWM_ACT 2'b01
`define CTM_PWM_WAVE 2'b10

// =====================================================================
// reset values
`define CTM_MODE_RST 8'h00
`define CTM_CMPA_RST 10'h000
`define CTM_P_RST 3'h0
`define CTM_PRE_RST 8'h00

`endif

// ---- common/ctm_pkg.sv ----
// types shared by the compact match/pwm timer
`include "ctm_cfg.svh"
package ctm_pkg;

  // ===================================================================
  // output and mode control byte, msb first
  typedef struct packed {
    logic [1:0] mode_sel;
    logic [1:0] out_action_sel;
    logic out_init_level;
    logic out_invert;
    logic pwm_role_swap;
    logic clear_source_sel;
  } ctm_mode_reg_t;

  // ===================================================================
  // whole state of the timer and its bus slave
  typedef struct packed {
    logic [7:0] addr;
    logic pend;
    logic wr;
    logic rdy;
    logic [31:0] rdata;
    logic resp;
    logic counter_on;
    logic on_prev;
    logic [`CTM_P_W-1:0] compare_p_value;
    logic [`CTM_PRE_W-1:0] pre;
    logic [`CTM_PRE_W-1:0] div;
    ctm_mode_reg_t mreg;
    logic [`CTM_CNT_W-1:0] compare_a_value;
    logic [`CTM_CNT_W-1:0] cnt;
    logic match_a_flag;
    logic match_p_flag;
    logic lvl;
    logic pin;
    logic pin_en;
  } ctm_state_t;

endpackage

// ---- hdl/ctm_timer.sv ----
// compact 10-bit match/pwm timer with an ahb-lite register slave
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_timer
  import ctm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic timer_output_pin,
  output logic timer_output_pin_en
);

  // ===================================================================
  // state
  ctm_state_t s_q;
  ctm_state_t s_d;

  logic accept;
  logic tick;
  logic rise;
  logic [`CTM_CNT_W-1:0] nxt;
  logic a_hit;
  logic p_hit;
  logic clr;
  logic set_a;
  logic set_p;
  logic clr_a;
  logic clr_p;
  logic [`CTM_CNT_W-1:0] duty;
  logic raw;
  logic act;
  logic sig;
  logic [31:0] rd;

  // ===================================================================
  // read mux, from current state
  always_comb begin
    rd = 32'h0000_0000;
    unique case (s_q.addr)
      `CTM_OFS_CTRL: begin
        rd[`CTM_CTRL_P_LSB +: `CTM_P_W] = s_q.compare_p_value;
        rd[`CTM_CTRL_ON_BIT] = s_q.counter_on;
        rd[`CTM_CTRL_PRE_LSB +: `CTM_PRE_W] = s_q.pre;
      end
      `CTM_OFS_MODE: begin
        rd[7:0] = s_q.mreg;
      end
      `CTM_OFS_COUNT: begin
        rd[`CTM_CNT_W-1:0] = s_q.cnt;
      end
      `CTM_OFS_CMPA: begin
        rd[`CTM_CNT_W-1:0] = s_q.compare_a_value;
      end
      `CTM_OFS_FLAGS: begin
        rd[`CTM_FLAG_A_BIT] = s_q.match_a_flag;
        rd[`CTM_FLAG_P_BIT] = s_q.match_p_flag;
      end
      `CTM_OFS_STAT: begin
        rd[`CTM_STAT_PIN_BIT] = s_q.pin;
        rd[`CTM_STAT_EN_BIT] = s_q.pin_en;
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase
  end

  // ===================================================================
  // next state
  always_comb begin
    s_d = s_q;
    clr_a = 1'b0;
    clr_p = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    clr = 1'b0;

    // bus: one wait state so hrdata can come from a flop
    accept = hsel & htrans[1] & hready;
    if (s_q.pend) begin
      s_d.pend = 1'b0;
      s_d.rdy = 1'b1;
      if (s_q.wr) begin
        unique case (s_q.addr)
          `CTM_OFS_CTRL: begin
            s_d.compare_p_value = hwdata[`CTM_CTRL_P_LSB +: `CTM_P_W];
            s_d.counter_on = hwdata[`CTM_CTRL_ON_BIT];
            s_d.pre = hwdata[`CTM_CTRL_PRE_LSB +: `CTM_PRE_W];
          end
          `CTM_OFS_MODE: begin
            s_d.mreg = ctm_mode_reg_t'(hwdata[7:0]);
          end
          `CTM_OFS_CMPA: begin
            s_d.compare_a_value = hwdata[`CTM_CNT_W-1:0];
          end
          `CTM_OFS_FLAGS: begin
            clr_a = hwdata[`CTM_FLAG_A_BIT];
            clr_p = hwdata[`CTM_FLAG_P_BIT];
          end
          default: begin
            clr_a = 1'b0;
          end
        endcase
      end else begin
        s_d.rdata = rd;
      end
    end
    if (accept) begin
      s_d.pend = 1'b1;
      s_d.rdy = 1'b0;
      s_d.wr = hwrite;
      s_d.addr = {haddr[7:2], 2'b00};
    end

    // timer clock enable from the prescaler
    tick = (s_q.div == s_q.pre);
    s_d.div = tick ? `CTM_PRE_W'(0) : `CTM_PRE_W'(s_q.div + 1'b1);

    s_d.on_prev = s_q.counter_on;
    rise = s_q.counter_on & ~s_q.on_prev;

    nxt = `CTM_CNT_W'(s_q.cnt + 1'b1);
    // zero A value never matches, so a counter cleared by A just wraps
    a_hit = (nxt == s_q.compare_a_value) && (s_q.compare_a_value != '0);
    // P lands on 128-count steps; zero means overflow
    p_hit = (nxt[`CTM_CNT_W-1:`CTM_P_SHIFT] == s_q.compare_p_value)
          && (nxt[`CTM_P_SHIFT-1:0] == '0);

    if (rise) begin
      s_d.cnt = '0;
      s_d.lvl = s_q.mreg.out_init_level;
    end else if (s_q.counter_on && tick) begin
      if (s_q.mreg.mode_sel == `CTM_MODE_PWM) begin
        // clear source ignored here; period value clears
        clr = s_q.mreg.pwm_role_swap ? a_hit : p_hit;
        set_a = a_hit;
        set_p = p_hit;
      end else begin
        // compare and timer modes count and clear alike; only compare mode drives the level
        clr = s_q.mreg.clear_source_sel ? a_hit : p_hit;
        set_a = a_hit;
        set_p = p_hit & ~s_q.mreg.clear_source_sel;
        if (a_hit && s_q.mreg.mode_sel == `CTM_MODE_CMP) begin
          // same level as present gives no visible change
          unique case (s_q.mreg.out_action_sel)
            `CTM_IO_LOW: s_d.lvl = 1'b0;
            `CTM_IO_HIGH: s_d.lvl = 1'b1;
            `CTM_IO_TGL: s_d.lvl = ~s_q.lvl;
            `CTM_IO_HOLD: s_d.lvl = s_q.lvl;
          endcase
        end
      end
      s_d.cnt = clr ? `CTM_CNT_W'(0) : nxt;
    end

    // set wins over a software clear in the same cycle
    s_d.match_a_flag = (s_q.match_a_flag & ~clr_a) | set_a;
    s_d.match_p_flag = (s_q.match_p_flag & ~clr_p) | set_p;

    // pin, computed from next state so it lines up with the counter
    duty = s_q.mreg.pwm_role_swap ? {s_q.compare_p_value, `CTM_P_SHIFT'(0)}
                                  : s_q.compare_a_value;
    raw = (s_d.cnt < duty);
    unique case (s_q.mreg.out_action_sel)
      `CTM_PWM_INACT: act = 1'b0;
      `CTM_PWM_ACT: act = 1'b1;
      `CTM_PWM_WAVE: act = raw;
      default: act = 1'b0;
    endcase
    // active level chosen by the init level bit
    sig = act ? s_q.mreg.out_init_level : ~s_q.mreg.out_init_level;
    unique case (s_q.mreg.mode_sel)
      `CTM_MODE_CMP: begin
        s_d.pin = s_d.lvl ^ s_q.mreg.out_invert;
        s_d.pin_en = 1'b1;
      end
      `CTM_MODE_PWM: begin
        s_d.pin = sig ^ s_q.mreg.out_invert;
        s_d.pin_en = 1'b1;
      end
      default: begin
        // pin left to other functions in timer mode
        s_d.pin = 1'b0;
        s_d.pin_en = 1'b0;
      end
    endcase
    s_d.resp = 1'b0;
  end

  // ===================================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{addr: 8'h00, pend: 1'b0, wr: 1'b0, rdy: 1'b1,
               rdata: 32'h0000_0000, resp: 1'b0, counter_on: 1'b0,
               on_prev: 1'b0, compare_p_value: `CTM_P_RST,
               pre: `CTM_PRE_RST, div: 8'h00,
               mreg: ctm_mode_reg_t'(`CTM_MODE_RST),
               compare_a_value: `CTM_CMPA_RST, cnt: 10'h000,
               match_a_flag: 1'b0, match_p_flag: 1'b0, lvl: 1'b0,
               pin: 1'b0, pin_en: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.rdy;
  assign hresp = s_q.resp;
  assign timer_output_pin = s_q.pin;
  assign timer_output_pin_en = s_q.pin_en;

endmodule

// ---- verif/ctm_pin_load.sv ----
// load on the timer output pin: pull-down wire with edge and level counters
`timescale 1ns/1ps
module ctm_pin_load (
  input wire logic hclk,
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_en,
  output logic wire_lvl,
  output int rise_n,
  output int high_n
);
  // a released pin falls to the pull-down level
  assign wire_lvl = timer_output_pin_en ? timer_output_pin : 1'b0;
  initial begin
    rise_n = 0;
    high_n = 0;
  end
  // sampled mid-cycle so the bench can read counts race-free at the rising edge
  always @(negedge hclk) begin
    high_n <= high_n + int'(wire_lvl);
  end
  always @(posedge wire_lvl) begin
    rise_n <= rise_n + 1;
  end
endmodule

// ---- verif/ctm_timer_monitor.sv ----
// assertion checker for the timer bus handshake and pin
`timescale 1ns/1ps
module ctm_timer_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_en
);
  logic ap_q;
  logic aw_q;
  logic [5:0] aa_q;
  logic [7:0] md_q;
  logic on_q;
  logic [2:0] st_q;
  wire take = hsel && htrans[1] && hready;
  wire done = ap_q && hreadyout && aw_q;
  wire ok = st_q > 3'h2;
  wire cmp = md_q[7:6] == 2'b00;
  wire lvl = timer_output_pin ^ md_q[2];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========
  // shadow of mode and enable; a control or mode write restarts the settle count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      aw_q <= 1'b0;
      aa_q <= 6'h0;
      md_q <= 8'h0;
      on_q <= 1'b0;
      st_q <= 3'h0;
    end else begin
      ap_q <= take || (ap_q && !hreadyout);
      aw_q <= take ? hwrite : aw_q;
      aa_q <= take ? haddr[7:2] : aa_q;
      if (done && aa_q == 6'h1) md_q <= hwdata[7:0];
      if (done && aa_q == 6'h0) on_q <= hwdata[3];
      if (done && aa_q < 6'h2) st_q <= 3'h0;
      else if (st_q != 3'h7) st_q <= st_q + 3'h1;
    end
  end
  sequence s_take;
    hsel && htrans[1] && hready;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_wait;
    s_take |=> s_wait;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_unmapped;
    take && !hwrite && haddr[7:0] > 8'h17 |=> s_wait ##0 hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pin_en;
    ok |-> timer_output_pin_en == !md_q[6];
  endproperty
  a_pin_en: assert property (p_pin_en) else $error("pin enable wrong");
  property p_pwm_force;
    ok && md_q[7:6] == 2'b10 && !md_q[5] |-> lvl == (md_q[3] ~^ md_q[4]);
  endproperty
  a_pwm_force: assert property (p_pwm_force) else $error("forced level wrong");
  property p_cmp_init;
    $rose(on_q) && cmp |-> ##[0:2] lvl == md_q[3];
  endproperty
  a_cmp_init: assert property (p_cmp_init) else $error("initial level wrong");
  property p_cmp_hold;
    ok && cmp && md_q[5:4] == 2'b00 |-> $stable(timer_output_pin);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("pin moved on hold");
  property p_cmp_high;
    ok && cmp && md_q[5:4] == 2'b10 |-> !$fell(lvl);
  endproperty
  a_cmp_high: assert property (p_cmp_high) else $error("pin fell on set");
endmodule
bind ctm_timer ctm_timer_monitor u_ctm_timer_monitor (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .timer_output_pin(timer_output_pin),
  .timer_output_pin_en(timer_output_pin_en));

// ---- verif/testbench.sv ----
// self-checking bench for the compact match/pwm timer
`timescale 1ns/1ps
`include "ctm_cfg.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench;
  import ctm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] seed = 32'h24c7c4fc;
  logic [31:0] hrdata, r, fl;
  logic [9:0] cn;
  logic hreadyout, hresp, pin, pin_en, wl;
  int fail_count = 0;
  int checks_done = 0;
  int rise_n, high_n, h0, e0, hw;
  ctm_timer u_ctm_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_output_pin(pin),
    .timer_output_pin_en(pin_en));
  ctm_pin_load u_ctm_pin_load (.hclk(hclk), .timer_output_pin(pin),
    .timer_output_pin_en(pin_en), .wire_lvl(wl), .rise_n(rise_n), .high_n(high_n));
  initial begin
    forever #4 hclk = ~hclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // ==========
  // bus master: every step hangs on hready as the slave samples it at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    // read data is taken at the very edge that ends the data phase
    r = hrdata;
  endtask
  // mode is only changed with the timer off
  task automatic go(input logic [7:0] m, input logic [9:0] a, input logic [2:0] p,
                    input int n);
    xfer(1'b1, `CTM_OFS_CTRL, 32'h0);
    xfer(1'b1, `CTM_OFS_MODE, {24'h0, m});
    xfer(1'b1, `CTM_OFS_CMPA, {22'h0, a});
    xfer(1'b1, `CTM_OFS_FLAGS, 32'h3);
    e0 = rise_n;
    xfer(1'b1, `CTM_OFS_CTRL, {29'h1, p});
    h0 = high_n;
    repeat (n) @(posedge hclk);
    hw = high_n - h0;
    xfer(1'b1, `CTM_OFS_CTRL, 32'h0);
    xfer(1'b0, `CTM_OFS_FLAGS, 32'h0);
    fl = r;
    xfer(1'b0, `CTM_OFS_COUNT, 32'h0);
    cn = r[9:0];
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
  initial begin
    logic [9:0] a;
    logic [7:0] m;
    logic [1:0] io;
    int per, an;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, `CTM_OFS_MODE, 32'h0);
    `CHK("mode reset", 32'h0, r)
    xfer(1'b1, 8'h18, 32'hffffffff);
    xfer(1'b0, 8'h18, 32'h0);
    `CHK("unmapped", 32'h0, r)
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      io = 2'(i);
      a = 10'd3 + 10'(rnd() % 16);
      m = {2'b00, io, 2'(rnd()), 2'b01};
      go(m, a, 3'h0, 40 * int'(a));
      `CHK("cmp flags", 32'h1, fl)
      `CHK("cmp count", 1'b1, cn < a)
      if (io == 2'b11) `CHK("toggles", 1'b1, (rise_n - e0) inside {[19:22]})
      else `CHK("cmp level", io[1] | (~io[0] & m[3]), wl ^ m[2])
    end
    $display("test compare done");
    for (int i = 0; i < 6; i++) begin
      io = (i < 4) ? 2'b10 : 2'(5 - i);
      m = {2'b10, io, 1'(rnd()), i[1], i[0], 1'(rnd())};
      a = m[1] ? 10'd200 + 10'(rnd() % 50) : 10'd10 + 10'(rnd() % 100);
      per = m[1] ? int'(a) : 128;
      an = m[1] ? 256 : 2 * int'(a);
      an = (io == 2'b10) ? an : ((io == 2'b01) ? 2 * per : 0);
      go(m, a, 3'h1, 2 * per);
      `CHK("pwm high", (m[3] ^ m[2]) ? an : 2 * per - an, hw)
      `CHK("pwm flags", 32'h3, fl)
    end
    $display("test pwm done");
    go(8'he1, 10'd20, 3'h0, 100);
    `CHK("tc pin_en", 1'b0, pin_en)
    `CHK("tc wire", 1'b0, wl)
    `CHK("tc flags", 32'h1, fl)
    xfer(1'b0, `CTM_OFS_STAT, 32'h0);
    `CHK("tc stat", 32'h0, r)
    // the undefined mode code must leave the pin released as well
    go(8'h41, 10'd20, 3'h0, 60);
    `CHK("undef pin_en", 1'b0, pin_en)
    go(8'h00, 10'd50, 3'h1, 300);
    `CHK("p flags", 32'h3, fl)
    `CHK("p count", 1'b1, cn < 10'd128)
    go(8'h00, 10'd0, 3'h0, 300);
    `CHK("no early clear", 1'b1, cn >= 10'd300)
    go(8'h01, 10'd0, 3'h0, 1100);
    `CHK("wrap flags", 32'h0, fl)
    `CHK("wrap count", 1'b1, cn < 10'd200)
    $display("test clear done");
    complete_run();
  end
endmodule
